// *** hw/dsss_defines.svh ***
// Register offsets, field positions, reset values and limits of the spread-spectrum transceiver
`ifndef DSSS_DEFINES_SVH
`define DSSS_DEFINES_SVH
`define OFS_CTRL        7'h00
`define OFS_BURST_LO    7'h01
`define OFS_BURST_HI    7'h02
`define OFS_PRE_LEN     7'h03
`define OFS_DATA_LEN    7'h04
`define OFS_CHIP_DIV    7'h05
`define OFS_THRESH      7'h06
`define OFS_NCO_LO      7'h07
`define OFS_NCO_HI      7'h08
`define OFS_LOOP_SHIFT  7'h09
`define OFS_GATE        7'h0a
`define OFS_PRE_CODE    7'h10
`define OFS_DATA_CODE   7'h18
`define OFS_STATUS      7'h20
`define OFS_SYM_LO      7'h21
`define OFS_SYM_HI      7'h22
`define OFS_MISS_LO     7'h23
`define OFS_MISS_HI     7'h24
`define BIT_RX_ON       0
`define BIT_TX_ON       1
`define BIT_NCO_ON      2
`define BIT_BURST       3
`define BIT_QUAD        4
`define BIT_TX_START    5
`define BIT_RX_ABORT    6
`define RST_CTRL        8'h00
`define RST_BURST_LEN   16'h0010
`define RST_CODE_LEN    7'h0b
`define RST_CHIP_DIV    8'h04
`define MIN_CHIP_DIV    8'h04
`define RST_THRESH      7'h08
`define RST_GATE        6'h02
`define MAX_BURST_LEN   16'hfffd
`define MAX_CODE_LEN    7'h40
`define NCO_FREQ_MAX    16'h8000
`endif

// *** hw/dsss_pkg.sv ***
// Types shared by the spread-spectrum transceiver
package dsss_pkg;
    typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_HUNT = 3'b010, RX_TRACK = 3'b100} rxState_t;
    typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_PRE = 3'b010, TX_DATA = 3'b100} txState_t;
    typedef struct packed {
        logic               waitReq;    // Bus wait, high when idle
        logic [7:0]         rdData;     // Read answer
        logic               rxOn;       // Section enables
        logic               txOn;
        logic               ncoOn;
        logic               burstMode;  // 1 burst, 0 continuous
        logic               quadMode;   // 1 quadrature, 0 direct I.F.
        logic [15:0]        burstLen;
        logic [6:0]         preLen;
        logic [6:0]         dataLen;
        logic [7:0]         chipDiv;
        logic [6:0]         thresh;
        logic [15:0]        ncoFreq;
        logic [3:0]         loopShift;
        logic [5:0]         gate;
        logic [63:0]        preCode;
        logic [63:0]        dataCode;
        logic [7:0]         iS1;        // Pin synchronisers
        logic [7:0]         iS2;
        logic [7:0]         qS1;
        logic [7:0]         qS2;
        logic [2:0]         pinS1;      // rx enable, tx enable, tx data
        logic [2:0]         pinS2;
        logic [15:0]        phase;
        logic signed [15:0] freqAdj;
        logic signed [15:0] qAcc;
        logic [7:0]         chipCnt;
        logic [63:0]        chipHist;
        rxState_t           rxState;
        logic [6:0]         chipInSym;
        logic [15:0]        symCount;
        logic [15:0]        missed;
        logic               symStrobe;
        logic               sampleStrobe;
        logic               rxAbort;
        txState_t           txState;
        logic [7:0]         txChipCnt;
        logic [6:0]         txChipIdx;
        logic [15:0]        txSymCount;
        logic               txBit;
        logic               txChip;
        logic               txActive;
    } state_t;
endpackage

// *** hw/dsss_burst_transceiver.sv ***
// Burst spread-spectrum transceiver: downconversion, matched filter, symbol timing, spreader, registers
//
// Overview of operation
// - One I.F. sample taken every clock
// - Quadrature mode downconverts I and Q complex
// - NCO frequency capped at half clock
// - Loop filter closes frequency tracking loop
// - Burst length bounded, at most 65533 symbols
// - Continuous mode never ends by count
// - Matched filter acquires within one symbol
// - One preamble symbol with own code first
// - Flywheel inserts symbol pulse when peak missed
// - Missed-detect counter counts inserted pulses
// - Timing gate restricts accepted correlation peaks
// - Receiver and transmitter enabled independently
// - NCO switchable off on its own
// - Sleep disables receiver, transmitter and NCO
// - Host address is 7 bits wide
// - Host data 8 bits, select active low
// - Chip rate at most quarter clock rate
// - Code lengths programmable up to 64 chips
// - Code period aligned to each symbol
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dsss_defines.svh"
module dsss_burst_transceiver (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [6:0] address,          // Avalon register address
    input  wire logic       read,
    input  wire logic       write,
    input  wire logic [7:0] writedata,
    input  wire logic       host_select_n,    // Active-low chip select
    output logic [7:0]      readdata,
    output logic            waitrequest,
    input  wire logic [7:0] rx_inphase_sample_in,
    input  wire logic [7:0] rx_quadrature_sample_in,
    input  wire logic       manual_rx_enable,
    input  wire logic       manual_tx_enable,
    input  wire logic       tx_data_in,
    output logic            rx_symbol_strobe,
    output logic            rx_sample_strobe,
    output logic            rx_active,
    output logic            tx_active,
    output logic            tx_chip_out
);
    dsss_pkg::state_t st;       // All state
    dsss_pkg::state_t nx;       // Next state

    // Count of code chips matching the received history over the code length
    function automatic logic [6:0] popMatch(input logic [63:0] h, input logic [63:0] c, input logic [6:0] len);
        logic [6:0] m;
        m = 7'h00;
        for (int j = 0; j < 64; j++) begin
            if (j < int'(len) && h[j] == c[j]) begin
                m = m + 7'h01;
            end
        end
        return m;
    endfunction

    // Correlation magnitude |2*matches - length|
    function automatic logic [6:0] corrMag(input logic [6:0] m, input logic [6:0] len);
        logic signed [8:0] d;
        d = $signed({1'b0, m, 1'b0}) - $signed({2'b00, len});
        return d[8] ? 7'(-d) : d[6:0];
    endfunction

    // Code length kept between 1 and 64 chips
    function automatic logic [6:0] clampLen(input logic [7:0] v);
        if (v == 8'h00) begin
            return 7'h01;
        end
        return (v > 8'h40) ? `MAX_CODE_LEN : v[6:0];
    endfunction

    // Register read decode; unmapped offsets read as zero
    function automatic logic [7:0] readReg(input dsss_pkg::state_t s, input logic [6:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a >= `OFS_PRE_CODE && a < `OFS_PRE_CODE + 7'h08) begin
            r = s.preCode[8 * int'(a[2:0]) +: 8];
        end else if (a >= `OFS_DATA_CODE && a < `OFS_DATA_CODE + 7'h08) begin
            r = s.dataCode[8 * int'(a[2:0]) +: 8];
        end else begin
            case (a)
                `OFS_CTRL:       r = {3'h0, s.quadMode, s.burstMode, s.ncoOn, s.txOn, s.rxOn};
                `OFS_BURST_LO:   r = s.burstLen[7:0];
                `OFS_BURST_HI:   r = s.burstLen[15:8];
                `OFS_PRE_LEN:    r = {1'b0, s.preLen};
                `OFS_DATA_LEN:   r = {1'b0, s.dataLen};
                `OFS_CHIP_DIV:   r = s.chipDiv;
                `OFS_THRESH:     r = {1'b0, s.thresh};
                `OFS_NCO_LO:     r = s.ncoFreq[7:0];
                `OFS_NCO_HI:     r = s.ncoFreq[15:8];
                `OFS_LOOP_SHIFT: r = {4'h0, s.loopShift};
                `OFS_GATE:       r = {2'b00, s.gate};
                `OFS_STATUS:     r = {2'b00, s.txState, s.rxState};
                `OFS_SYM_LO:     r = s.symCount[7:0];
                `OFS_SYM_HI:     r = s.symCount[15:8];
                `OFS_MISS_LO:    r = s.missed[7:0];
                `OFS_MISS_HI:    r = s.missed[15:8];
                default:         r = 8'h00;
            endcase
        end
        return r;
    endfunction

    logic              rxEn;        // Receiver enabled by register or pin
    logic              txEn;        // Transmitter enabled by register or pin
    logic              doWrite;     // Write takes effect this edge
    logic              chipTick;    // Receive chip instant
    logic              txTick;      // Transmit chip instant
    logic              txGo;        // Start request taken while idle
    logic signed [8:0] inI;         // Sign-extended samples
    logic signed [8:0] inQ;
    logic signed [8:0] bbI;         // Baseband after complex mix
    logic signed [8:0] bbQ;
    logic [63:0]       hist;        // Chip history including this chip
    logic [6:0]        preMag;
    logic [6:0]        dataMag;
    logic              inGate;      // Chip lies in the timing gate
    logic              accepted;    // Gated peak taken as detection
    logic              inserted;    // Flywheel pulse this chip
    logic signed [17:0] freqSum;    // Base plus loop correction
    logic [15:0]       effFreq;     // Clamped NCO step

    // Next-state logic for the whole block
    always_comb begin
        nx = st;
        nx.symStrobe = 1'b0;
        nx.sampleStrobe = 1'b0;
        nx.rxAbort = 1'b0;
        // Pin inputs pass two flip-flops before use
        nx.iS1 = rx_inphase_sample_in;
        nx.iS2 = st.iS1;
        nx.qS1 = rx_quadrature_sample_in;
        nx.qS2 = st.qS1;
        nx.pinS1 = {tx_data_in, manual_tx_enable, manual_rx_enable};
        nx.pinS2 = st.pinS1;
        rxEn = st.rxOn | st.pinS2[0];
        txEn = st.txOn | st.pinS2[1];

        // Bus answer: waitrequest drops for exactly one cycle per request
        nx.waitReq = !((read | write) && st.waitReq);
        if ((read | write) && st.waitReq) begin
            nx.rdData = (read && !host_select_n) ? readReg(st, address) : 8'h00;
        end
        doWrite = write && !st.waitReq && !host_select_n;
        if (doWrite) begin
            if (address >= `OFS_PRE_CODE && address < `OFS_PRE_CODE + 7'h08) begin
                nx.preCode[8 * int'(address[2:0]) +: 8] = writedata;
            end else if (address >= `OFS_DATA_CODE && address < `OFS_DATA_CODE + 7'h08) begin
                nx.dataCode[8 * int'(address[2:0]) +: 8] = writedata;
            end else begin
                case (address)
                    `OFS_CTRL: begin
                        nx.rxOn = writedata[`BIT_RX_ON];
                        nx.txOn = writedata[`BIT_TX_ON];
                        nx.ncoOn = writedata[`BIT_NCO_ON];
                        nx.burstMode = writedata[`BIT_BURST];
                        nx.quadMode = writedata[`BIT_QUAD];
                        nx.rxAbort = writedata[`BIT_RX_ABORT];
                    end
                    `OFS_BURST_LO:   nx.burstLen[7:0] = writedata;
                    `OFS_BURST_HI:   nx.burstLen[15:8] = writedata;
                    `OFS_PRE_LEN:    nx.preLen = clampLen(writedata);
                    `OFS_DATA_LEN:   nx.dataLen = clampLen(writedata);
                    `OFS_CHIP_DIV:   nx.chipDiv = (writedata < `MIN_CHIP_DIV) ? `MIN_CHIP_DIV : writedata;
                    `OFS_THRESH:     nx.thresh = writedata[6:0];
                    `OFS_NCO_LO:     nx.ncoFreq[7:0] = writedata;
                    `OFS_NCO_HI:     nx.ncoFreq[15:8] = writedata;
                    `OFS_LOOP_SHIFT: nx.loopShift = writedata[3:0];
                    `OFS_GATE:       nx.gate = writedata[5:0];
                    default:         nx.rxOn = nx.rxOn;
                endcase
            end
        end
        // Burst length never outside 1..65533 symbols
        if (nx.burstLen > `MAX_BURST_LEN) begin
            nx.burstLen = `MAX_BURST_LEN;
        end else if (nx.burstLen == 16'h0000) begin
            nx.burstLen = 16'h0001;
        end

        // NCO: base step plus loop correction, clamped to half the clock
        freqSum = $signed({2'b00, st.ncoFreq}) + 18'(st.freqAdj);
        if (freqSum < 0) begin
            effFreq = 16'h0000;
        end else if (freqSum > $signed({2'b00, `NCO_FREQ_MAX})) begin
            effFreq = `NCO_FREQ_MAX;
        end else begin
            effFreq = freqSum[15:0];
        end
        if (st.ncoOn) begin
            nx.phase = st.phase + effFreq;
        end

        // Complex mix by a quarter-wave LO; direct mode has no Q input
        inI = $signed({st.iS2[7], st.iS2});
        inQ = st.quadMode ? $signed({st.qS2[7], st.qS2}) : 9'sh000;
        case (st.phase[15:14])
            2'b00:   begin bbI = inI;  bbQ = inQ;  end
            2'b01:   begin bbI = inQ;  bbQ = -inI; end
            2'b10:   begin bbI = -inI; bbQ = -inQ; end
            default: begin bbI = -inQ; bbQ = inI;  end
        endcase

        // Receive chip timing and sliding matched filter
        chipTick = rxEn && (st.chipCnt == st.chipDiv - 8'h01);
        nx.chipCnt = (chipTick || !rxEn) ? 8'h00 : st.chipCnt + 8'h01;
        hist = {st.chipHist[62:0], ~bbI[8]};
        preMag = corrMag(popMatch(hist, st.preCode, st.preLen), st.preLen);
        dataMag = corrMag(popMatch(hist, st.dataCode, st.dataLen), st.dataLen);
        inGate = ({1'b0, st.chipInSym} + {2'b00, st.gate}) >= ({1'b0, st.dataLen} - 8'h01);
        accepted = (dataMag > st.thresh) && inGate;
        inserted = !accepted && (st.chipInSym == st.dataLen - 7'h01);
        if (chipTick) begin
            nx.chipHist = hist;
            nx.sampleStrobe = 1'b1;
        end

        // Receive state machine
        case (st.rxState)
            dsss_pkg::RX_IDLE: begin
                if (rxEn) begin
                    nx.rxState = dsss_pkg::RX_HUNT;
                end
            end
            dsss_pkg::RX_HUNT: begin
                if (chipTick && preMag > st.thresh) begin
                    nx.rxState = dsss_pkg::RX_TRACK;
                    nx.symStrobe = 1'b1;
                    nx.chipInSym = 7'h00;
                    nx.symCount = 16'h0000;
                    nx.missed = 16'h0000;
                    nx.qAcc = 16'sh0000;
                end
            end
            dsss_pkg::RX_TRACK: begin
                if (chipTick) begin
                    nx.qAcc = st.qAcc + 16'(bbQ);
                    if (accepted || inserted) begin
                        nx.symStrobe = 1'b1;
                        nx.chipInSym = 7'h00;
                        nx.symCount = st.symCount + 16'h0001;
                        if (!accepted) begin
                            nx.missed = st.missed + 16'h0001;
                        end
                        nx.freqAdj = st.freqAdj - (st.qAcc >>> st.loopShift);
                        nx.qAcc = 16'sh0000;
                        if (st.burstMode && st.symCount + 16'h0001 >= st.burstLen) begin
                            nx.rxState = dsss_pkg::RX_HUNT;
                        end
                    end else begin
                        nx.chipInSym = st.chipInSym + 7'h01;
                    end
                end
            end
            default: nx.rxState = dsss_pkg::RX_IDLE;
        endcase
        if (st.rxAbort && st.rxState == dsss_pkg::RX_TRACK) begin
            nx.rxState = dsss_pkg::RX_HUNT;
        end
        if (!rxEn) begin
            nx.rxState = dsss_pkg::RX_IDLE;
        end

        // Transmit spreader: preamble code symbol, then data code symbols
        txTick = (st.txChipCnt == st.chipDiv - 8'h01);
        // Start honours the enable written in the same access, so one write can power up and start
        txGo = doWrite && address == `OFS_CTRL && writedata[`BIT_TX_START]
               && (writedata[`BIT_TX_ON] | st.pinS2[1]);
        nx.txChipCnt = (txTick || st.txState == dsss_pkg::TX_IDLE) ? 8'h00 : st.txChipCnt + 8'h01;
        case (st.txState)
            dsss_pkg::TX_IDLE: begin
                if (txGo) begin
                    nx.txState = dsss_pkg::TX_PRE;
                    nx.txChipIdx = st.preLen - 7'h01;
                    nx.txBit = 1'b0;
                    nx.txSymCount = 16'h0000;
                    nx.txActive = 1'b1;
                end
            end
            dsss_pkg::TX_PRE, dsss_pkg::TX_DATA: begin
                if (txTick) begin
                    nx.txChip = ((st.txState == dsss_pkg::TX_PRE) ? st.preCode[st.txChipIdx[5:0]]
                                 : st.dataCode[st.txChipIdx[5:0]]) ^ st.txBit;
                    if (st.txChipIdx != 7'h00) begin
                        nx.txChipIdx = st.txChipIdx - 7'h01;
                    end else begin
                        nx.txChipIdx = st.dataLen - 7'h01;
                        nx.txBit = st.pinS2[2];
                        if (st.txState == dsss_pkg::TX_PRE) begin
                            nx.txState = dsss_pkg::TX_DATA;
                        end else begin
                            nx.txSymCount = st.txSymCount + 16'h0001;
                            if (st.burstMode && st.txSymCount + 16'h0001 >= st.burstLen) begin
                                nx.txState = dsss_pkg::TX_IDLE;
                                nx.txActive = 1'b0;
                            end
                        end
                    end
                end
            end
            default: nx.txState = dsss_pkg::TX_IDLE;
        endcase
        if (!txEn && !txGo) begin
            nx.txState = dsss_pkg::TX_IDLE;
            nx.txActive = 1'b0;
        end
    end

    // State register; reset ends any burst and turns sections off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.waitReq <= 1'b1;
            st.burstLen <= `RST_BURST_LEN;
            st.preLen <= `RST_CODE_LEN;
            st.dataLen <= `RST_CODE_LEN;
            st.chipDiv <= `RST_CHIP_DIV;
            st.thresh <= `RST_THRESH;
            st.gate <= `RST_GATE;
            st.rxState <= dsss_pkg::RX_IDLE;
            st.txState <= dsss_pkg::TX_IDLE;
        end else begin
            st <= nx;
        end
    end

    assign readdata = st.rdData;
    assign waitrequest = st.waitReq;
    assign rx_symbol_strobe = st.symStrobe;
    assign rx_sample_strobe = st.sampleStrobe;
    assign rx_active = (st.rxState != dsss_pkg::RX_IDLE);
    assign tx_active = st.txActive;
    assign tx_chip_out = st.txChip;

    // Checks on the block's own behaviour
    sequence trackMiss_s;
        st.rxState == dsss_pkg::RX_TRACK && chipTick && inserted && rxEn && !st.rxAbort;
    endsequence
    sequence txStart_s;
        st.txState == dsss_pkg::TX_IDLE && txGo;
    endsequence
    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n) (read | write) && waitrequest |=> !waitrequest) else $error("bus answer late");
    burst_bound_a: assert property (@(posedge clk) disable iff (!rst_n) st.burstMode && st.rxState == dsss_pkg::RX_TRACK |-> st.symCount < st.burstLen) else $error("burst overran");
    flywheel_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) trackMiss_s |=> rx_symbol_strobe) else $error("no inserted pulse");
    missed_count_a: assert property (@(posedge clk) disable iff (!rst_n) trackMiss_s |=> st.missed == $past(st.missed) + 16'h0001) else $error("miss not counted");
    gate_only_a: assert property (@(posedge clk) disable iff (!rst_n) st.rxState == dsss_pkg::RX_TRACK && chipTick && !inGate && rxEn |=> !rx_symbol_strobe) else $error("peak outside gate");
    nco_cap_a: assert property (@(posedge clk) disable iff (!rst_n) effFreq <= `NCO_FREQ_MAX) else $error("nco step too high");
    nco_hold_a: assert property (@(posedge clk) disable iff (!rst_n) !st.ncoOn |=> $stable(st.phase)) else $error("nco ran while off");
    sleep_all_a: assert property (@(posedge clk) disable iff (!rst_n) (!rxEn && !txEn && !st.ncoOn) [*2] |-> !rx_active && !tx_active && $stable(st.phase)) else $error("sleep not honoured");
    preamble_first_a: assert property (@(posedge clk) disable iff (!rst_n) txStart_s |=> st.txState == dsss_pkg::TX_PRE && st.txChipIdx == st.preLen - 7'h01) else $error("burst lacks preamble");
endmodule
`default_nettype wire

// *** tb/adc_model.sv ***
// Behavioural model of the external converters feeding the receive inputs
`timescale 1ns/1ps
`default_nettype none
module adc_model (
    input  wire logic       clk,
    input  wire logic       chip,
    output logic [7:0]      iSample,
    output logic [7:0]      qSample
);
    // Chips arrive at zero I.F., so the alias rule leaves the NCO step at zero
    // One antipodal sample per clock, MSB is bit 7; Q idle since the bench uses direct mode
    always @(posedge clk) begin
        iSample <= chip ? 8'h40 : 8'hc0;
        qSample <= 8'h00;
    end
endmodule
`default_nettype wire

// *** tb/dsss_burst_transceiver_bench.sv ***
// Bench: register checks, transmit burst looped into receive, sleep and reset
`timescale 1ns/1ps
`default_nettype none
module dsss_burst_transceiver_bench;
    logic       clk = 1'b0;       // 200 MHz clock
    logic       rst_n = 1'b0;     // Reset, active low
    logic       read = 1'b0;      // Bus strobes
    logic       write = 1'b0;
    logic       hostSelN = 1'b0;  // Select, active low
    logic [6:0] address = 7'h00;
    logic [7:0] wrData = 8'h00;
    logic [7:0] rdData, iS, qS, got;
    logic       waitReq, symStb, smpStb, rxAct, txAct, chipOut;
    int         errors = 0, checks_done = 0, cyc = 0, symSeen = 0;
    int         smpSeen = 0, smpMark = 0;  // Sample strobe tally and window start
    always #2.5 clk = ~clk;
    dsss_burst_transceiver dsss_burst_transceiver_inst (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(wrData), .host_select_n(hostSelN), .readdata(rdData),
        .waitrequest(waitReq), .rx_inphase_sample_in(iS), .rx_quadrature_sample_in(qS),
        .manual_rx_enable(1'b0), .manual_tx_enable(1'b0), .tx_data_in(1'b1), .rx_symbol_strobe(symStb),
        .rx_sample_strobe(smpStb), .rx_active(rxAct), .tx_active(txAct), .tx_chip_out(chipOut));
    // Transmit chips loop straight back as receive samples
    adc_model adc_model_inst (.clk(clk), .chip(chipOut), .iSample(iS), .qSample(qS));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("Errors %0d, checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One bus access; held until a rising edge samples waitrequest low, data taken at that edge
    task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        write <= wr;
        read <= !wr;
        address <= a;
        wrData <= d;
        do @(posedge clk); while (waitReq !== 1'b0);
        got = rdData;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    // Strobe tallies and hang guard; tallies update late so readers see a settled count
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (symStb === 1'b1) symSeen <= symSeen + 1;
        if (smpStb === 1'b1) smpSeen <= smpSeen + 1;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, 7'h05, 8'h00);
        check(got, 8'h04);
        bus(0, 7'h01, 8'h00);
        check(got, 8'h10);
        bus(0, 7'h7f, 8'h00);
        check(got, 8'h00);
        // A deselected write must leave the threshold alone
        hostSelN <= 1'b1;
        bus(1, 7'h06, 8'h33);
        hostSelN <= 1'b0;
        bus(0, 7'h06, 8'h00);
        check(got, 8'h08);
        // Out-of-range lengths are clamped
        bus(1, 7'h02, 8'hff);
        bus(1, 7'h01, 8'hff);
        bus(0, 7'h01, 8'h00);
        check(got, 8'hfd);
        bus(1, 7'h04, 8'h7f);
        bus(0, 7'h04, 8'h00);
        check(got, 8'h40);
        bus(1, 7'h05, 8'h02);
        bus(0, 7'h05, 8'h00);
        check(got, 8'h04);
        // Burst of 3 data symbols of 8 chips; chipDiv 16 keeps direct mode legal
        bus(1, 7'h04, 8'h08);
        bus(1, 7'h02, 8'h00);
        bus(1, 7'h01, 8'h03);
        bus(1, 7'h05, 8'h10);
        bus(1, 7'h10, 8'h5a);
        bus(1, 7'h11, 8'h03);
        bus(1, 7'h00, 8'h2b);
        repeat (2) @(negedge clk);
        check(txAct, 1'b1);
        for (int k = 0; k < 3000 && txAct; k++) @(posedge clk);
        repeat (200) @(posedge clk);
        check(txAct, 1'b0);
        check(16'(symSeen), 16'h0004);
        // An 8-chip peak can never beat a threshold of 8, so every data symbol is an inserted pulse
        bus(0, 7'h23, 8'h00);
        check(got, 8'h03);
        bus(0, 7'h21, 8'h00);
        check(got, 8'h03);
        // Continuous mode keeps sending past any count; one sample strobe per 16 clocks
        bus(1, 7'h00, 8'h23);
        repeat (400) @(posedge clk);
        smpMark = smpSeen;
        repeat (1600) @(posedge clk);
        check(16'(smpSeen - smpMark), 16'h0064);
        check(txAct, 1'b1);
        bus(0, 7'h20, 8'h00);
        check(got, 8'h24);
        // Abort drops the receiver back to hunting while the transmitter goes on
        bus(1, 7'h00, 8'h63);
        bus(0, 7'h20, 8'h00);
        check(got, 8'h22);
        // Sleep: every section off
        bus(1, 7'h00, 8'h00);
        repeat (4) @(negedge clk);
        check({rxAct, txAct}, 2'b00);
        // Reset during continuous transmission
        bus(1, 7'h00, 8'h23);
        repeat (300) @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        check({rxAct, txAct, waitReq}, 3'b001);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        bus(0, 7'h21, 8'h00);
        check(got, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
